// ### verilog/ucs_ctrl.sv
// Serial port control and status register with APB access
// How it works
// - Receiver sets framing error flag when a stop bit is invalid.
// - Framing error flag stays set until software clears it.
// - Bit 7 shows mode high or framing error, chosen by framing select.
// - Mode bits pick shift, 8-bit variable, 9-bit fixed or 9-bit variable.
// - Register holds ninth bits and flags, writable as byte or single bit.
// - Multiprocessor mode drops receive flag when received ninth bit is 0 in 9-bit modes, or stop bit is invalid in 8-bit mode.
// - Transmit flag set at 8th bit end in shift mode, else stop start.
// - Fixed 9-bit rate is clock/16 with double rate, else clock/32.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ucs_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_done,
  input  wire logic        rx_stop_bit,
  input  wire logic        rx_ninth_in,
  input  wire logic        tx_bit8_end,
  input  wire logic        tx_stop_start,
  input  wire logic        timer_tick,
  output var  logic        mode_select_high,
  output var  logic        mode_select_low,
  output var  logic        multiprocessor_enable,
  output var  logic        rx_enable,
  output var  logic        tx_ninth_bit,
  output var  logic        baud_tick,
  output var  logic        irq
);
  // ****************
  // Bus decode
  // ****************
  logic       setup;
  logic       wr_acc;
  logic       ctrl_wr;
  logic       bit_wr;
  logic       any_wr;
  logic       clr_wr;
  logic [7:0] ctrl_view;
  logic [7:0] bw_val;
  logic [7:0] wval;
  logic [1:0] mode;

  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pready & pwrite;
  assign ctrl_wr = wr_acc & (paddr == ucs_pkg::OFS_CTRL);
  assign bit_wr  = wr_acc & (paddr == ucs_pkg::OFS_BIT_WR);
  assign any_wr  = ctrl_wr | bit_wr;
  assign clr_wr  = wr_acc & (paddr == ucs_pkg::OFS_IRQ_CLR);
  assign mode    = {mode_select_high, mode_select_low};

  // ****************
  // Control register state
  // ****************
  logic             fsel_q;
  logic             fsel_d;
  logic             drate_q;
  logic             drate_d;
  logic             mh_d;
  logic             ml_d;
  logic             mpe_d;
  logic             ren_d;
  logic             tb8_d;
  logic             rb8_q;
  logic             rb8_d;
  logic [2:0]       en_q;
  logic [2:0]       en_d;
  logic             irq_d;
  logic [ucs_pkg::NFLAG-1:0] fl_set;
  logic [ucs_pkg::NFLAG-1:0] fl_wr;
  logic [ucs_pkg::NFLAG-1:0] fl_val;
  logic [ucs_pkg::NFLAG-1:0] fl_q;
  logic             nine_bit;
  logic             rx_drop;
  logic             rx_acc;
  logic             fe_set;
  logic             tx_set;

  assign ctrl_view = {fsel_q ? fl_q[ucs_pkg::FL_FE] : mode_select_high,
                      mode_select_low, multiprocessor_enable, rx_enable,
                      tx_ninth_bit, rb8_q, fl_q[ucs_pkg::FL_TI], fl_q[ucs_pkg::FL_RI]};

  // Single bit write replaces one bit of the current view
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bw
      assign bw_val[gi] = (pwdata[2:0] == 3'(gi)) ? pwdata[ucs_pkg::BIT_BW_VAL] : ctrl_view[gi];
    end
  endgenerate

  assign wval = ctrl_wr ? pwdata[7:0] : bw_val;

  // ****************
  // Serial events
  // ****************
  assign nine_bit = mode[1];
  assign rx_drop  = multiprocessor_enable &
                    ((nine_bit & ~rx_ninth_in) | ((mode == ucs_pkg::MODE_8BIT) & ~rx_stop_bit));
  assign rx_acc   = rx_done & rx_enable & ~rx_drop;
  assign fe_set   = rx_done & rx_enable & (mode != ucs_pkg::MODE_SHIFT) & ~rx_stop_bit;
  assign tx_set   = (mode == ucs_pkg::MODE_SHIFT) ? tx_bit8_end : tx_stop_start;

  always_comb begin
    fl_set = '0;
    fl_wr  = '0;
    fl_val = '0;
    fl_set[ucs_pkg::FL_TI] = tx_set;
    fl_set[ucs_pkg::FL_RI] = rx_acc;
    fl_set[ucs_pkg::FL_FE] = fe_set;
    fl_set[ucs_pkg::ST_TI] = tx_set;
    fl_set[ucs_pkg::ST_RI] = rx_acc;
    fl_set[ucs_pkg::ST_FE] = fe_set;
    fl_wr[ucs_pkg::FL_TI]  = any_wr;
    fl_val[ucs_pkg::FL_TI] = wval[ucs_pkg::BIT_TI];
    fl_wr[ucs_pkg::FL_RI]  = any_wr;
    fl_val[ucs_pkg::FL_RI] = wval[ucs_pkg::BIT_RI];
    fl_wr[ucs_pkg::FL_FE]  = any_wr & fsel_q;
    fl_val[ucs_pkg::FL_FE] = wval[ucs_pkg::BIT_MODE_HI];
    fl_wr[ucs_pkg::ST_TI]  = clr_wr & pwdata[0];
    fl_wr[ucs_pkg::ST_RI]  = clr_wr & pwdata[1];
    fl_wr[ucs_pkg::ST_FE]  = clr_wr & pwdata[2];
  end

  generate
    for (gi = 0; gi < ucs_pkg::NFLAG; gi++) begin : g_flag
      ucs_flag u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (fl_set[gi]),
        .wr      (fl_wr[gi]),
        .wr_val  (fl_val[gi]),
        .q       (fl_q[gi])
      );
    end
  endgenerate

  always_comb begin
    mh_d    = mode_select_high;
    ml_d    = mode_select_low;
    mpe_d   = multiprocessor_enable;
    ren_d   = rx_enable;
    tb8_d   = tx_ninth_bit;
    rb8_d   = rb8_q;
    fsel_d  = fsel_q;
    drate_d = drate_q;
    en_d    = en_q;
    if (any_wr) begin
      if (!fsel_q) begin
        mh_d = wval[ucs_pkg::BIT_MODE_HI];
      end
      ml_d  = wval[ucs_pkg::BIT_MODE_LO];
      mpe_d = wval[ucs_pkg::BIT_MPE];
      ren_d = wval[ucs_pkg::BIT_REN];
      tb8_d = wval[ucs_pkg::BIT_TB8];
      rb8_d = wval[ucs_pkg::BIT_RB8];
    end
    if (rx_acc) begin
      if (nine_bit) begin
        rb8_d = rx_ninth_in;
      end else if (mode == ucs_pkg::MODE_8BIT && !multiprocessor_enable) begin
        rb8_d = rx_stop_bit;
      end
    end
    if (wr_acc && paddr == ucs_pkg::OFS_PWR) begin
      fsel_d  = pwdata[ucs_pkg::BIT_FSEL];
      drate_d = pwdata[ucs_pkg::BIT_DRATE];
    end
    if (wr_acc && paddr == ucs_pkg::OFS_IRQ_EN) begin
      en_d = pwdata[2:0];
    end
    irq_d = |(fl_q[ucs_pkg::ST_FE:ucs_pkg::ST_TI] & en_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_select_high      <= ucs_pkg::RST_CTRL[ucs_pkg::BIT_MODE_HI];
      mode_select_low       <= ucs_pkg::RST_CTRL[ucs_pkg::BIT_MODE_LO];
      multiprocessor_enable <= ucs_pkg::RST_CTRL[ucs_pkg::BIT_MPE];
      rx_enable             <= ucs_pkg::RST_CTRL[ucs_pkg::BIT_REN];
      tx_ninth_bit          <= ucs_pkg::RST_CTRL[ucs_pkg::BIT_TB8];
      rb8_q                 <= ucs_pkg::RST_CTRL[ucs_pkg::BIT_RB8];
      fsel_q                <= ucs_pkg::RST_PWR[ucs_pkg::BIT_FSEL];
      drate_q               <= ucs_pkg::RST_PWR[ucs_pkg::BIT_DRATE];
      en_q                  <= ucs_pkg::RST_EN;
      irq                   <= 1'b0;
    end else begin
      mode_select_high      <= mh_d;
      mode_select_low       <= ml_d;
      multiprocessor_enable <= mpe_d;
      rx_enable             <= ren_d;
      tx_ninth_bit          <= tb8_d;
      rb8_q                 <= rb8_d;
      fsel_q                <= fsel_d;
      drate_q               <= drate_d;
      en_q                  <= en_d;
      irq                   <= irq_d;
    end
  end

  // ****************
  // APB answer: read data and error captured at setup, ready in access
  // ****************
  logic [31:0] prdata_d;
  logic        pslverr_d;
  logic        pready_d;

  always_comb begin
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    pready_d  = setup;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        ucs_pkg::OFS_CTRL:     prdata_d[7:0] = ctrl_view;
        ucs_pkg::OFS_PWR:      prdata_d[1:0] = {drate_q, fsel_q};
        ucs_pkg::OFS_IRQ_STAT: prdata_d[2:0] = fl_q[ucs_pkg::ST_FE:ucs_pkg::ST_TI];
        ucs_pkg::OFS_IRQ_EN:   prdata_d[2:0] = en_q;
        ucs_pkg::OFS_IRQ_CLR,
        ucs_pkg::OFS_BIT_WR:   prdata_d = 32'h0000_0000;
        default:               pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      prdata  <= prdata_d;
      pslverr <= pslverr_d;
      pready  <= pready_d;
    end
  end

  ucs_baud u_baud (
    .pclk        (pclk),
    .presetn     (presetn),
    .mode        (mode),
    .double_rate (drate_q),
    .timer_tick  (timer_tick),
    .tick_q      (baud_tick)
  );

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_fe_set;
    fe_set |=> fl_q[ucs_pkg::FL_FE] && fl_q[ucs_pkg::ST_FE];
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing error not flagged");

  property p_fe_hold;
    fl_q[ucs_pkg::FL_FE] && !(any_wr && fsel_q) |=> fl_q[ucs_pkg::FL_FE];
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("framing error dropped without write");

  property p_bit7_read;
    setup && !pwrite && paddr == 8'h98 |=>
      prdata[7] == ($past(fsel_q) ? $past(fl_q[2]) : $past(mode_select_high));
  endproperty
  a_bit7_read: assert property (p_bit7_read) else $error("bit 7 read shows wrong source");

  property p_bit7_write;
    ctrl_wr && fsel_q |=> $stable(mode_select_high);
  endproperty
  a_bit7_write: assert property (p_bit7_write) else $error("mode high written while hidden");

  property p_rb8;
    rx_acc && nine_bit |=> rb8_q == $past(rx_ninth_in);
  endproperty
  a_rb8: assert property (p_rb8) else $error("received ninth bit not stored");

  property p_mp_drop;
    rx_done && multiprocessor_enable && nine_bit && !rx_ninth_in
      && !fl_q[ucs_pkg::FL_RI] && !any_wr |=> !fl_q[ucs_pkg::FL_RI];
  endproperty
  a_mp_drop: assert property (p_mp_drop) else $error("receive flag raised for address 0");

  property p_tx_shift;
    mode == 2'h0 && tx_bit8_end |=> fl_q[ucs_pkg::FL_TI];
  endproperty
  a_tx_shift: assert property (p_tx_shift) else $error("transmit flag missed in shift mode");

  property p_irq;
    fl_q[3] && en_q[0] |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled status did not raise irq");
endmodule
`default_nettype wire

// ### verilog/ucs_pkg.sv
// Constants for the serial port control and status register block
package ucs_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] OFS_CTRL     = 8'h98;
  localparam logic [7:0] OFS_PWR      = 8'h9C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hA0;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'hA4;
  localparam logic [7:0] OFS_IRQ_EN   = 8'hA8;
  localparam logic [7:0] OFS_BIT_WR   = 8'hAC;

  // ****************
  // Control register bit positions
  // ****************
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_MPE     = 5;
  localparam int BIT_REN     = 4;
  localparam int BIT_TB8     = 3;
  localparam int BIT_RB8     = 2;
  localparam int BIT_TI      = 1;
  localparam int BIT_RI      = 0;

  // Power control bits, bit write fields
  localparam int BIT_FSEL    = 0;
  localparam int BIT_DRATE   = 1;
  localparam int BIT_BW_VAL  = 3;

  // ****************
  // Reset values
  // ****************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] RST_PWR  = 2'h0;
  localparam logic [2:0] RST_EN   = 3'h0;

  // ****************
  // Flags: control copies then interrupt status copies
  // ****************
  localparam int NFLAG = 6;
  localparam int FL_TI = 0;
  localparam int FL_RI = 1;
  localparam int FL_FE = 2;
  localparam int ST_TI = 3;
  localparam int ST_RI = 4;
  localparam int ST_FE = 5;

  // ****************
  // Modes and fixed baud divisors
  // ****************
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT  = 2'h1;
  localparam logic [1:0] MODE_9FIX  = 2'h2;
  localparam logic [5:0] DIV_SHIFT  = 6'h06;
  localparam logic [5:0] DIV_SLOW   = 6'h20;
  localparam logic [5:0] DIV_FAST   = 6'h10;
  localparam logic [5:0] DIV_NONE   = 6'h00;
endpackage

// ### verilog/ucs_flag.sv
// Sticky flag with hardware set taking priority over software write
`timescale 1ns/1ps
`default_nettype none
module ucs_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic wr,
  input  wire logic wr_val,
  output var  logic q
);
  logic q_d;

  always_comb begin
    q_d = q;
    if (set) begin
      q_d = 1'b1;
    end else if (wr) begin
      q_d = wr_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn) set |=> q;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost a hardware set");
endmodule
`default_nettype wire

// ### verilog/ucs_baud.sv
// Baud tick generator for fixed and timer driven rates
`timescale 1ns/1ps
`default_nettype none
module ucs_baud (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] mode,
  input  wire logic       double_rate,
  input  wire logic       timer_tick,
  output var  logic       tick_q
);
  logic [5:0] div;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic       tick_d;

  always_comb begin
    unique case (mode)
      ucs_pkg::MODE_SHIFT: div = ucs_pkg::DIV_SHIFT;
      ucs_pkg::MODE_9FIX:  div = double_rate ? ucs_pkg::DIV_FAST : ucs_pkg::DIV_SLOW;
      default:             div = ucs_pkg::DIV_NONE;
    endcase
    if (div == ucs_pkg::DIV_NONE) begin
      cnt_d  = 6'h00;
      tick_d = timer_tick;
    end else if (cnt_q >= div - 6'h01) begin
      cnt_d  = 6'h00;
      tick_d = 1'b1;
    end else begin
      cnt_d  = cnt_q + 6'h01;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  property p_div_shift;
    @(posedge pclk) disable iff (!presetn) mode == 2'h0 |-> div == 6'h06;
  endproperty
  a_div_shift: assert property (p_div_shift) else $error("shift mode divisor wrong");

  property p_div_fix;
    @(posedge pclk) disable iff (!presetn)
      mode == 2'h2 |-> div == (double_rate ? 6'h10 : 6'h20);
  endproperty
  a_div_fix: assert property (p_div_fix) else $error("fixed rate divisor wrong");
endmodule
`default_nettype wire

// ### testbench/ucs_station.sv
// Remote serial station model driving the receive, transmit and timer events
`timescale 1ns/1ps
`default_nettype none
module ucs_station (
  input  wire logic pclk,
  output var  logic rx_done,
  output var  logic rx_stop_bit,
  output var  logic rx_ninth_in,
  output var  logic tx_bit8_end,
  output var  logic tx_stop_start,
  output var  logic timer_tick
);
  initial begin
    rx_done       = 1'b0;
    rx_stop_bit   = 1'b1;
    rx_ninth_in   = 1'b1;
    tx_bit8_end   = 1'b0;
    tx_stop_start = 1'b0;
    timer_tick    = 1'b0;
  end

  // One received character; qualifiers inverted once released
  task automatic send_char(input logic stop, input logic ninth);
    rx_done     <= 1'b1;
    rx_stop_bit <= stop;
    rx_ninth_in <= ninth;
    @(posedge pclk);
    rx_done     <= 1'b0;
    rx_stop_bit <= ~stop;
    rx_ninth_in <= ~ninth;
  endtask

  // Transmit progress pulse: 0 end of eighth bit, 1 start of stop bit
  task automatic tx_pulse(input logic stop_kind);
    if (stop_kind) tx_stop_start <= 1'b1;
    else tx_bit8_end <= 1'b1;
    @(posedge pclk);
    tx_stop_start <= 1'b0;
    tx_bit8_end   <= 1'b0;
  endtask

  task automatic tick();
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### testbench/ucs_ctrl_tb_top.sv
// Self-checking bench for the serial port control and status register
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module ucs_ctrl_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  wire logic   rx_done, rx_stop_bit, rx_ninth_in, tx_bit8_end, tx_stop_start, timer_tick;
  logic        mode_select_high, mode_select_low, multiprocessor_enable;
  logic        rx_enable, tx_ninth_bit, baud_tick, irq;
  int          failures, num_checks;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [7:0]  lfsr_q, d;

  ucs_ctrl ucs_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_done(rx_done), .rx_stop_bit(rx_stop_bit), .rx_ninth_in(rx_ninth_in),
    .tx_bit8_end(tx_bit8_end), .tx_stop_start(tx_stop_start), .timer_tick(timer_tick),
    .mode_select_high(mode_select_high), .mode_select_low(mode_select_low),
    .multiprocessor_enable(multiprocessor_enable), .rx_enable(rx_enable),
    .tx_ninth_bit(tx_ninth_bit), .baud_tick(baud_tick), .irq(irq));
  ucs_station ucs_station_i (.pclk(pclk), .rx_done(rx_done), .rx_stop_bit(rx_stop_bit),
    .rx_ninth_in(rx_ninth_in), .tx_bit8_end(tx_bit8_end), .tx_stop_start(tx_stop_start),
    .timer_tick(timer_tick));

  // ****************
  // Clock, tasks
  // ****************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Waits for pready without a limit; the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    xfer(1'b1, a, {24'h000000, wd});
  endtask

  // Note expected error bit and data, monitor compares
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic err = 1'b0);
    exp_q.push_back({err, 24'h000000, ed});
    xfer(1'b0, a, 32'h00000000);
  endtask

  task automatic chk_per(input int want);
    int n;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin @(posedge pclk); n++; end while (baud_tick !== 1'b1 && n < 100);
    end
    `CHK(n, want)
  endtask

  task automatic endt(input string name);
    $display("test %s done", name);
  endtask

  // ****************
  // Read monitor
  // ****************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_v = exp_q.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("watchdog expired");
    summarize();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; failures = 0; num_checks = 0; lfsr_q = 8'h42;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ucs_pkg::OFS_CTRL, 8'h00);
    rd(ucs_pkg::OFS_PWR, 8'h00);
    rd(ucs_pkg::OFS_IRQ_STAT, 8'h00);
    rd(ucs_pkg::OFS_IRQ_EN, 8'h00);
    rd(8'hB0, 8'h00, 1'b1);
    endt("reset");
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      d = lfsr_q & 8'hFB;
      wr(ucs_pkg::OFS_CTRL, d);
      rd(ucs_pkg::OFS_CTRL, d);
      `CHK({mode_select_high, mode_select_low, multiprocessor_enable, rx_enable, tx_ninth_bit}, d[7:3])
    end
    wr(ucs_pkg::OFS_CTRL, 8'h00);
    wr(ucs_pkg::OFS_BIT_WR, 8'h0C);
    rd(ucs_pkg::OFS_CTRL, 8'h10);
    `CHK(rx_enable, 1'b1)
    endt("byte and bit access");
    chk_per(6);
    wr(ucs_pkg::OFS_CTRL, 8'h80);
    chk_per(32);
    wr(ucs_pkg::OFS_PWR, 8'h02);
    chk_per(16);
    wr(ucs_pkg::OFS_PWR, 8'h00);
    wr(ucs_pkg::OFS_CTRL, 8'h40);
    ucs_station_i.tick();
    @(posedge pclk);
    `CHK(baud_tick, 1'b1)
    endt("modes");
    wr(ucs_pkg::OFS_PWR, 8'h01);
    wr(ucs_pkg::OFS_CTRL, 8'h50);
    wr(ucs_pkg::OFS_IRQ_EN, 8'h04);
    ucs_station_i.send_char(1'b0, 1'b1);
    rd(ucs_pkg::OFS_CTRL, 8'hD1);
    `CHK(irq, 1'b1)
    ucs_station_i.send_char(1'b1, 1'b0);
    rd(ucs_pkg::OFS_CTRL, 8'hD5);
    wr(ucs_pkg::OFS_CTRL, 8'h50);
    rd(ucs_pkg::OFS_CTRL, 8'h50);
    `CHK(mode_select_high, 1'b0)
    rd(ucs_pkg::OFS_IRQ_STAT, 8'h06);
    wr(ucs_pkg::OFS_IRQ_CLR, 8'h07);
    rd(ucs_pkg::OFS_IRQ_STAT, 8'h00);
    `CHK(irq, 1'b0)
    endt("framing error and interrupt");
    wr(ucs_pkg::OFS_PWR, 8'h00);
    wr(ucs_pkg::OFS_CTRL, 8'hB0);
    ucs_station_i.send_char(1'b1, 1'b0);
    rd(ucs_pkg::OFS_CTRL, 8'hB0);
    ucs_station_i.send_char(1'b1, 1'b1);
    rd(ucs_pkg::OFS_CTRL, 8'hB5);
    endt("multiprocessor");
    wr(ucs_pkg::OFS_CTRL, 8'h00);
    ucs_station_i.tx_pulse(1'b0);
    rd(ucs_pkg::OFS_CTRL, 8'h02);
    wr(ucs_pkg::OFS_CTRL, 8'h40);
    ucs_station_i.tx_pulse(1'b1);
    rd(ucs_pkg::OFS_CTRL, 8'h42);
    fork
      wr(ucs_pkg::OFS_CTRL, 8'h40);
      begin repeat (1) @(posedge pclk); ucs_station_i.tx_pulse(1'b1); end
    join
    rd(ucs_pkg::OFS_CTRL, 8'h42);
    rd(ucs_pkg::OFS_IRQ_STAT, 8'h03);
    `CHK(irq, 1'b0)
    wr(ucs_pkg::OFS_IRQ_EN, 8'h01);
    @(posedge pclk);
    `CHK(irq, 1'b1)
    endt("transmit flag");
    repeat (2) @(posedge pclk);
    summarize();
  end
endmodule
`default_nettype wire
